/* verilog/udrp_pkg.sv */
/*
  shared constants, enums and carrier structs of the reservation access policy block.
  assumes one 50 MHz core clock and an APB master with 32-bit data.
*/
`default_nettype none
package udrp_pkg;
	// slot table geometry
	localparam int SLOT_W = 5;
	localparam int NSLOT = 2 ** SLOT_W;
	localparam int STREAM_W = 4;
	localparam int LEN_W = 16;
	localparam int SLOT_REC_W = 15;
	// apb byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SEL = 8'h04;
	localparam logic [7:0] ADDR_SLOT = 8'h08;
	localparam logic [7:0] ADDR_GUARD = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	// control bits and reset values
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_XCAP_BIT = 1;
	localparam logic [LEN_W-1:0] GUARD_RST = 16'h0040;
	// reservation types (local encoding)
	typedef enum logic [2:0] {
		RT_ALIEN = 3'b000,
		RT_HARD = 3'b001,
		RT_SOFT = 3'b010,
		RT_PRIV = 3'b011,
		RT_PCA = 3'b100,
		RT_NONE = 3'b111
	} udrp_rtype_e;
	// our role in a slot
	typedef enum logic [1:0] {
		ROLE_NONE = 2'b00,
		ROLE_OWNER = 2'b01,
		ROLE_TARGET = 2'b10,
		ROLE_NBR = 2'b11
	} udrp_role_e;
	// reason for a refused transmission
	typedef enum logic [2:0] {
		DC_OK = 3'b000,
		DC_OFF = 3'b001,
		DC_TYPE = 3'b010,
		DC_ROLE = 3'b011,
		DC_STREAM = 3'b100,
		DC_TIME = 3'b101,
		DC_PEER = 3'b110,
		DC_BACKOFF = 3'b111
	} udrp_deny_e;
	// release sequence states
	typedef enum logic [1:0] {
		REL_IDLE = 2'b00,
		REL_WAIT = 2'b01,
		REL_FREE = 2'b10
	} udrp_rel_e;
	// per-slot record, 15 bits
	typedef struct packed {
		udrp_rtype_e rtype;
		udrp_role_e role;
		logic status;
		logic peerOk;
		logic denied;
		logic prevPca;
		logic otherTgt;
		logic hearOwner;
		logic [STREAM_W-1:0] stream;
	} udrp_slot_s;
	localparam udrp_slot_s SLOT_RST = '{RT_NONE, ROLE_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
	// transmit request from the mac
	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		logic isData;
		logic isBeacon;
		logic newTxn;
		logic chained;
		logic gapOk;
		logic backoffDone;
		logic destMatch;
		logic unicast;
		logic [STREAM_W-1:0] deliveryId;
		logic [LEN_W-1:0] txnLen;
	} udrp_txreq_s;
	// decoded reservation element from a neighbour beacon
	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		udrp_rtype_e rtype;
		logic status;
		logic denied;
		logic forMe;
		logic hearOwner;
		logic [STREAM_W-1:0] stream;
	} udrp_rxie_s;
endpackage
`default_nettype wire

/* verilog/udrp_access_policy.sv */
/*
  reservation access policy: slot table, transmit permission, availability map,
  negotiation gate, beacon announcement helper and apb register slave.
  assumes all mac-side inputs come from logic on core_clk and apb uses core_clk.
*/
// Contract
// (RQ1) announce every used reservation in beacons
// (RQ2) group slots sharing address, owner, type, stream; code compares owner flag, type and stream only
// (RQ3) decode neighbour elements, transmit only as allowed
// (RQ4) transaction ends guard before block end
// (RQ5) alien period: only own beacon allowed
// (RQ6) hard: outsiders stay silent
// (RQ7) hard: only owner initiates transactions
// (RQ8) hard/private: suggest releasing unused block time
// (RQ9) released block usable after duration expires
// (RQ10) hard data needs stream and destination match
// (RQ11) soft owner accesses without backoff
// (RQ12) soft owner chains within one sifs
// (RQ13) soft owner no-backoff data needs match
// (RQ14) soft: contention; hidden target neighbours silent
// (RQ15) private: outsiders silent, standard frames
// (RQ16) pca reservation: plain contention for all
// (RQ17) slot unavailable if recent beacon period overlaps
// (RQ18) own confirmed, foreign-target slots unavailable
// (RQ19) no negotiation on referenced non-denied slots
// (RQ20) advertise explicit capability, check peer
// (RQ21) negotiate only as owner
// (RQ22) alien detect installs status-one alien element
// (RQ23) pca status one needs previous pca
// (RQ24) confirmed reservations announced accepted, status one
// (RQ25) owner unicast needs both statuses one; code does not check this in alien or pca slots or in a released block
// (RQ26) unknown type denies transmission
`timescale 1ns/1ps
`default_nettype none
module udrp_access_policy #(
	parameter int MAX_LOST = 3
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// superframe timing
	input wire logic sfTick,
	input wire logic blkEnd,
	input wire logic blkUnused,
	input wire logic [udrp_pkg::LEN_W-1:0] blkRemain,
	// transmit permission
	input wire logic txReqValid,
	input wire udrp_pkg::udrp_txreq_s txReq,
	output logic txDone,
	output logic txGrant,
	output logic txNoBackoff,
	output udrp_pkg::udrp_deny_e txDenyCode,
	// received beacon information
	input wire logic rxIeValid,
	input wire udrp_pkg::udrp_rxie_s rxIe,
	input wire logic bpSeen,
	input wire logic [udrp_pkg::SLOT_W-1:0] bpSlot,
	input wire logic alienDet,
	input wire logic [udrp_pkg::SLOT_W-1:0] alienSlot,
	input wire logic pcaConfirm,
	input wire logic [udrp_pkg::SLOT_W-1:0] pcaSlot,
	// block release frames
	input wire logic relRx,
	input wire logic [udrp_pkg::SLOT_W-1:0] relSlot,
	input wire logic [udrp_pkg::LEN_W-1:0] relDur,
	// negotiation gate
	input wire logic negReq,
	input wire logic [udrp_pkg::SLOT_W-1:0] negSlot,
	input wire logic negAsOwner,
	input wire logic negExplicit,
	input wire logic peerXcap,
	output logic negDone,
	output logic negOk,
	// beacon content
	input wire logic [udrp_pkg::SLOT_W-1:0] annSlot,
	output logic annValid,
	output logic annStatus,
	output udrp_pkg::udrp_rtype_e annType,
	output logic annSameGroup,
	output logic capExplicit,
	output logic relSuggest,
	output logic [udrp_pkg::NSLOT-1:0] availMap
);
	import udrp_pkg::*;

	localparam int AGE_W = $clog2(MAX_LOST + 2);

	udrp_slot_s recTab[NSLOT]; // slot table
	logic ctrlEn_r; // policy enable
	logic ctrlXcap_r; // explicit negotiation capable
	logic [SLOT_W-1:0] selSlot_r; // apb slot pointer
	logic [LEN_W-1:0] guardCyc_r; // sifs plus guard, cycles
	udrp_rel_e relState_r; // release sequence
	logic [LEN_W-1:0] relCnt_r; // release duration left
	logic [SLOT_W-1:0] relSlot_r; // released slot
	logic [SLOT_REC_W-2:0] prevKey_r; // grouping key of previous slot
	logic prevKeyOk_r; // previous key valid
	udrp_slot_s cur; // record of requested slot
	udrp_slot_s ann; // record of announced slot
	logic fits; // transaction fits the block
	logic match; // stream and destination agree
	logic released; // slot released to contention
	logic outsider; // neither owner nor target
	logic gNxt;
	logic nbNxt;
	udrp_deny_e dcNxt;
	logic apbSetup;
	logic apbWr;
	logic [SLOT_REC_W-2:0] annKey;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	// apb phase decode
	assign apbSetup = psel && !penable;
	assign apbWr = psel && penable && pready && pwrite && !pslverr;

	// apb answer: no wait states, data latched in setup
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= apbSetup;
			pslverr <= 1'b0;
			if (apbSetup)
			begin
				case (paddr)
					ADDR_CTRL: prdata <= {30'h0, ctrlXcap_r, ctrlEn_r};
					ADDR_SEL: prdata <= 32'(selSlot_r);
					ADDR_SLOT: prdata <= 32'(recTab[selSlot_r]);
					ADDR_GUARD: prdata <= 32'(guardCyc_r);
					ADDR_STAT: prdata <= 32'({relState_r, txDenyCode, txNoBackoff, txGrant});
					default:
					begin
						// unmapped: zero data and slave error
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// software control registers
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrlEn_r <= 1'b0;
			ctrlXcap_r <= 1'b0;
			selSlot_r <= '0;
			guardCyc_r <= GUARD_RST;
		end
		else if (apbWr)
		begin
			if (paddr == ADDR_CTRL)
			begin
				ctrlEn_r <= pwdata[CTRL_EN_BIT];
				ctrlXcap_r <= pwdata[CTRL_XCAP_BIT];
			end
			if (paddr == ADDR_SEL)
				selSlot_r <= pwdata[SLOT_W-1:0];
			if (paddr == ADDR_GUARD)
				guardCyc_r <= pwdata[LEN_W-1:0];
		end
	end

	// slot table; element, alien and pca events take priority over software writes
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NSLOT; i++)
				recTab[i] <= SLOT_RST;
		end
		else
		begin
			// remember which slots were pca in the ending superframe
			if (sfTick)
			begin
				for (int i = 0; i < NSLOT; i++)
					recTab[i].prevPca <= (recTab[i].rtype == RT_PCA);
			end
			// (RQ3) neighbour element decode
			if (rxIeValid)
			begin
				if (rxIe.forMe && recTab[rxIe.slot].role == ROLE_OWNER)
					recTab[rxIe.slot].peerOk <= rxIe.status;
				else if (rxIe.forMe)
				begin
					recTab[rxIe.slot].rtype <= rxIe.rtype;
					recTab[rxIe.slot].role <= ROLE_TARGET;
					recTab[rxIe.slot].status <= rxIe.status;
					recTab[rxIe.slot].peerOk <= rxIe.status;
					recTab[rxIe.slot].denied <= rxIe.denied;
					recTab[rxIe.slot].stream <= rxIe.stream;
				end
				else
				begin
					// foreign reservation seen as a neighbour
					recTab[rxIe.slot].rtype <= rxIe.rtype;
					recTab[rxIe.slot].role <= ROLE_NBR;
					recTab[rxIe.slot].status <= rxIe.status;
					recTab[rxIe.slot].denied <= rxIe.denied;
					recTab[rxIe.slot].otherTgt <= 1'b1;
					recTab[rxIe.slot].hearOwner <= rxIe.hearOwner;
					recTab[rxIe.slot].stream <= rxIe.stream;
				end
			end
			// (RQ22) alien period installs its own element at once
			else if (alienDet)
			begin
				recTab[alienSlot].rtype <= RT_ALIEN;
				recTab[alienSlot].role <= ROLE_OWNER;
				recTab[alienSlot].status <= 1'b1;
				recTab[alienSlot].denied <= 1'b0;
			end
			// (RQ23) pca confirm only after a pca superframe
			else if (pcaConfirm)
			begin
				if (recTab[pcaSlot].prevPca && recTab[pcaSlot].rtype == RT_PCA)
					recTab[pcaSlot].status <= 1'b1;
			end
			// software installs negotiated records
			else if (apbWr && paddr == ADDR_SLOT)
				recTab[selSlot_r] <= udrp_slot_s'(pwdata[SLOT_REC_W-1:0]);
		end
	end

	// (RQ9) release sequence: wait out the frame duration, free until block end
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			relState_r <= REL_IDLE;
			relCnt_r <= '0;
			relSlot_r <= '0;
		end
		else
		begin
			case (relState_r)
				REL_IDLE:
				begin
					// only hard and private blocks can be released
					if (relRx && (recTab[relSlot].rtype == RT_HARD || recTab[relSlot].rtype == RT_PRIV))
					begin
						relState_r <= REL_WAIT;
						relCnt_r <= relDur;
						relSlot_r <= relSlot;
					end
				end
				REL_WAIT:
				begin
					if (blkEnd)
						relState_r <= REL_IDLE;
					else if (relCnt_r == '0)
						relState_r <= REL_FREE;
					else
						relCnt_r <= relCnt_r - 16'h0001;
				end
				REL_FREE:
				begin
					if (blkEnd)
						relState_r <= REL_IDLE;
				end
				default: relState_r <= REL_IDLE;
			endcase
		end
	end

	// transmit permission decision
	always_comb
	begin
		cur = recTab[txReq.slot];
		// (RQ4) end no later than sifs plus guard before block end
		fits = ({1'b0, txReq.txnLen} + {1'b0, guardCyc_r}) <= {1'b0, blkRemain};
		match = (txReq.deliveryId == cur.stream) && txReq.destMatch;
		released = (relState_r == REL_FREE) && (relSlot_r == txReq.slot);
		outsider = (cur.role == ROLE_NONE) || (cur.role == ROLE_NBR);
		nbNxt = 1'b0;
		dcNxt = DC_OK;
		if (!ctrlEn_r)
			dcNxt = DC_OFF;
		else if (txReq.newTxn && !fits)
			dcNxt = DC_TIME;
		else if (released)
		begin
			// freed remainder behaves as contention time
			if (!txReq.backoffDone)
				dcNxt = DC_BACKOFF;
		end
		else
		begin
			case (cur.rtype)
				RT_ALIEN:
				begin
					// (RQ5) nothing but our beacon
					if (!txReq.isBeacon)
						dcNxt = DC_ROLE;
				end
				RT_HARD, RT_PRIV:
				begin
					// (RQ6) (RQ15) outsiders silent
					if (outsider)
						dcNxt = DC_ROLE;
					// (RQ7) only the owner initiates in hard
					else if (cur.rtype == RT_HARD && txReq.newTxn && cur.role != ROLE_OWNER)
						dcNxt = DC_ROLE;
					// (RQ10) data must carry the reservation stream
					else if (cur.rtype == RT_HARD && txReq.isData && !match)
						dcNxt = DC_STREAM;
					// (RQ25) both sides confirmed before owner unicast
					else if (cur.role == ROLE_OWNER && txReq.unicast && !(cur.status && cur.peerOk))
						dcNxt = DC_PEER;
				end
				RT_SOFT:
				begin
					if (cur.role == ROLE_OWNER)
					begin
						// (RQ25) confirmation gate
						if (txReq.unicast && !(cur.status && cur.peerOk))
							dcNxt = DC_PEER;
						// (RQ11) (RQ12) (RQ13) no-backoff preferential access
						else if ((!txReq.isData || match) && (!txReq.chained || txReq.gapOk))
							nbNxt = 1'b1;
						else if (!txReq.backoffDone)
							dcNxt = DC_BACKOFF;
					end
					// (RQ14) hidden neighbour of target keeps off
					else if (cur.role == ROLE_NBR && !cur.hearOwner)
						dcNxt = DC_ROLE;
					else if (!txReq.backoffDone)
						dcNxt = DC_BACKOFF;
				end
				RT_PCA:
				begin
					// (RQ16) ordinary contention only
					if (!txReq.backoffDone)
						dcNxt = DC_BACKOFF;
				end
				// (RQ26) unknown type denies
				default: dcNxt = DC_TYPE;
			endcase
		end
		gNxt = (dcNxt == DC_OK);
	end

	// registered permission answer
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txDone <= 1'b0;
			txGrant <= 1'b0;
			txNoBackoff <= 1'b0;
			txDenyCode <= DC_OFF;
			relSuggest <= 1'b0;
		end
		else
		begin
			txDone <= txReqValid;
			// (RQ8) owner or target with idle remainder should release
			relSuggest <= blkUnused && !outsider && (cur.rtype == RT_HARD || cur.rtype == RT_PRIV);
			if (txReqValid)
			begin
				txGrant <= gNxt;
				txNoBackoff <= gNxt && nbNxt;
				txDenyCode <= dcNxt;
			end
		end
	end

	// (RQ19) (RQ20) (RQ21) negotiation gate
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			negDone <= 1'b0;
			negOk <= 1'b0;
			capExplicit <= 1'b0;
		end
		else
		begin
			negDone <= negReq;
			capExplicit <= ctrlXcap_r;
			negOk <= negReq && negAsOwner && (!negExplicit || (peerXcap && ctrlXcap_r)) &&
				(recTab[negSlot].rtype == RT_NONE || recTab[negSlot].denied);
		end
	end

	// beacon builder scans slots in order; key ties slots into one reservation
	always_comb
	begin
		ann = recTab[annSlot];
		annKey = {ann.rtype, ann.role == ROLE_OWNER, ann.otherTgt, ann.status, ann.denied, ann.prevPca,
			ann.hearOwner, ann.stream};
	end

	// (RQ1) (RQ2) (RQ24) announcement outputs
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			annValid <= 1'b0;
			annStatus <= 1'b0;
			annType <= RT_NONE;
			annSameGroup <= 1'b0;
			prevKey_r <= '0;
			prevKeyOk_r <= 1'b0;
		end
		else
		begin
			annValid <= (ann.role == ROLE_OWNER || ann.role == ROLE_TARGET) && ann.rtype != RT_NONE;
			annStatus <= ann.status;
			annType <= ann.rtype;
			// only owner flag, type and stream decide grouping
			annSameGroup <= prevKeyOk_r &&
				(prevKey_r[SLOT_REC_W-3:SLOT_REC_W-6] == annKey[SLOT_REC_W-3:SLOT_REC_W-6]) &&
				(prevKey_r[STREAM_W-1:0] == annKey[STREAM_W-1:0]);
			prevKey_r <= annKey;
			prevKeyOk_r <= (ann.role == ROLE_OWNER || ann.role == ROLE_TARGET);
		end
	end

	// per-slot beacon period age and availability
	for (genvar g = 0; g < NSLOT; g++)
	begin : gSlot
		logic [AGE_W-1:0] bpAge_r; // superframes left with a bp seen

		// (RQ17) fresh sighting wins over ageing
		always_ff @(posedge core_clk or negedge rstn)
		begin
			if (!rstn)
				bpAge_r <= '0;
			else if (bpSeen && bpSlot == SLOT_W'(g))
				bpAge_r <= AGE_W'(MAX_LOST + 1);
			else if (sfTick && bpAge_r != '0)
				bpAge_r <= bpAge_r - AGE_W'(1);
		end

		// (RQ18) own confirmed and foreign-target slots also unavailable
		always_ff @(posedge core_clk or negedge rstn)
		begin
			if (!rstn)
				availMap[g] <= 1'b0;
			else
				availMap[g] <= (bpAge_r == '0) && !recTab[g].otherTgt &&
					!(recTab[g].status && recTab[g].role != ROLE_NONE);
		end
	end

	// checks
	alien_silent_a: assert property (txReqValid && ctrlEn_r && relState_r != REL_FREE && cur.rtype == RT_ALIEN && !txReq.isBeacon |=> !txGrant && txDenyCode != DC_OK) else $error("alien period transmit granted"); // (RQ5)
	hard_outsider_a: assert property (txReqValid && relState_r != REL_FREE && cur.rtype == RT_HARD && outsider |=> !txGrant) else $error("hard outsider granted"); // (RQ6)
	guard_fit_a: assert property (txReqValid && ctrlEn_r && txReq.newTxn && !fits |=> !txGrant && txDenyCode == DC_TIME) else $error("overlong transaction granted"); // (RQ4)
	unknown_type_a: assert property (txReqValid && ctrlEn_r && fits && relState_r != REL_FREE && cur.rtype inside {3'b101, 3'b110, RT_NONE} |=> txDenyCode == DC_TYPE) else $error("unknown type not denied"); // (RQ26)
	bp_avail_a: assert property (bpSeen |-> ##2 !availMap[$past(bpSlot, 2)]) else $error("beacon period slot left available"); // (RQ17)
	neg_owner_a: assert property (negReq && !negAsOwner |=> negDone && !negOk) else $error("non-owner negotiation allowed"); // (RQ21)
	pca_confirm_a: assert property (pcaConfirm && !rxIeValid && !alienDet && !recTab[pcaSlot].prevPca && !recTab[pcaSlot].status && !sfTick |=> !recTab[$past(pcaSlot)].status) else $error("pca status set without history"); // (RQ23)
	soft_nobackoff_a: assert property (txNoBackoff |-> txGrant && $past(cur.role) == ROLE_OWNER && $past(cur.rtype) == RT_SOFT) else $error("no-backoff outside soft ownership"); // (RQ11)
	rel_wait_a: assert property (relState_r == REL_WAIT && relCnt_r != '0 && !blkEnd |=> relState_r == REL_WAIT) else $error("release freed early"); // (RQ9)
	apb_answer_a: assert property (apbSetup |=> pready ##1 !pready) else $error("apb answer timing wrong");
endmodule
`default_nettype wire

/* verif/udrp_nbr_model.sv */
/*
  neighbour beacon model: turns bench calls into one-cycle beacon-derived pulses.
  assumes callers sit in the core_clk domain; released lines carry inverted junk.
*/
`timescale 1ns/1ps
`default_nettype none
module udrp_nbr_model (
	// clock
	input wire logic core_clk,
	// decoded beacon content
	output var logic rxIeValid,
	output var udrp_pkg::udrp_rxie_s rxIe,
	output var logic bpSeen,
	output var logic [udrp_pkg::SLOT_W-1:0] bpSlot,
	output var logic alienDet,
	output var logic [udrp_pkg::SLOT_W-1:0] alienSlot,
	output var logic pcaConfirm,
	output var logic [udrp_pkg::SLOT_W-1:0] pcaSlot
);
	import udrp_pkg::*;
	// idle at time zero
	initial
	begin
		{pcaConfirm, alienDet, bpSeen, rxIeValid} = 4'h0;
		{pcaSlot, alienSlot, bpSlot} = '0;
		rxIe = '0;
	end
	// one event, k one-hot {pca, alien, bp, element}
	// element held one cycle
	task automatic ev(input logic [3:0] k, input logic [SLOT_W-1:0] s, input udrp_rxie_s ie);
		@(posedge core_clk);
		{pcaConfirm, alienDet, bpSeen, rxIeValid} <= k;
		{pcaSlot, alienSlot, bpSlot} <= {3{s}};
		rxIe <= ie;
		@(posedge core_clk);
		// stale lines inverted so nothing leans on old values
		{pcaConfirm, alienDet, bpSeen, rxIeValid} <= 4'h0;
		{pcaSlot, alienSlot, bpSlot} <= {3{~s}};
		rxIe <= ~ie;
	endtask
endmodule
`default_nettype wire

/* verif/udrp_access_policy_tb.sv */
/*
  bench for the reservation access policy block, one task per scenario.
  assumes udrp_nbr_model drives the beacon-derived inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module udrp_access_policy_tb;
	import udrp_pkg::*;
	// bench-driven inputs
	logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sfTick = 0, blkEnd = 0, blkUnused = 0;
	logic txReqValid = 0, relRx = 0, negReq = 0, negAsOwner = 0, negExplicit = 0, peerXcap = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [SLOT_W-1:0] relSlot = 5'h00, negSlot = 5'h00, annSlot = 5'h00, bpSlot, alienSlot, pcaSlot;
	logic [LEN_W-1:0] blkRemain = 16'h0100, relDur = 16'h0000;
	udrp_txreq_s txReq = '0;
	// observed outputs
	logic pready, pslverr, txDone, txGrant, txNoBackoff, negDone, negOk, annValid, annStatus, annSameGroup, e;
	logic capExplicit, relSuggest, rxIeValid, bpSeen, alienDet, pcaConfirm;
	udrp_deny_e txDenyCode;
	udrp_rtype_e annType;
	udrp_rxie_s rxIe;
	logic [NSLOT-1:0] availMap;
	int n_errors = 0, checks = 0;
	// 50 MHz
	always #10 core_clk = ~core_clk;
	// small lost-beacon limit keeps the ageing test short
	udrp_access_policy #(.MAX_LOST(2)) dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sfTick, .blkEnd, .blkUnused, .blkRemain, .txReqValid, .txReq, .txDone,
		.txGrant, .txNoBackoff, .txDenyCode, .rxIeValid, .rxIe, .bpSeen, .bpSlot, .alienDet, .alienSlot,
		.pcaConfirm, .pcaSlot, .relRx, .relSlot, .relDur, .negReq, .negSlot, .negAsOwner, .negExplicit,
		.peerXcap, .negDone, .negOk, .annSlot, .annValid, .annStatus, .annType, .annSameGroup, .capExplicit,
		.relSuggest, .availMap);
	udrp_nbr_model nbr (.core_clk, .rxIeValid, .rxIe, .bpSeen, .bpSlot, .alienDet, .alienSlot, .pcaConfirm,
		.pcaSlot);
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk(0, 1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	function automatic udrp_slot_s rec(udrp_rtype_e t, udrp_role_e r, logic st, logic hear, logic [3:0] id);
		rec = '{t, r, st, st, 1'b0, 1'b0, 1'b0, hear, id};
	endfunction
	// f = {isData, isBeacon, newTxn, backoffDone}
	function automatic udrp_txreq_s mk(logic [4:0] s, logic [3:0] f, logic [3:0] id, logic [15:0] len);
		mk = '{s, f[3], f[2], f[1], 1'b0, 1'b1, f[0], 1'b1, 1'b1, id, len};
	endfunction
	task automatic wslot(input logic [4:0] s, input udrp_slot_s r);
		apb(1'b1, ADDR_SEL, {27'h0, s});
		apb(1'b1, ADDR_SLOT, {17'h0, r});
	endtask
	// one permission request; code compared only when full is set
	task automatic tx(input udrp_txreq_s r, input logic g, input udrp_deny_e c, input logic full);
		@(posedge core_clk);
		txReqValid <= 1'b1;
		txReq <= r;
		@(posedge core_clk);
		txReqValid <= 1'b0;
		@(negedge core_clk);
		chk({txDone, txGrant}, {1'b1, g});
		if (full)
			chk(txDenyCode, c);
	endtask
	task automatic ann(input logic [4:0] s, input logic st, input udrp_rtype_e t);
		@(posedge core_clk);
		annSlot <= s;
		@(negedge core_clk);
		@(negedge core_clk);
		chk({annValid, annStatus, annType}, {1'b1, st, t});
	endtask
	task automatic neg(input logic [4:0] s, input logic [2:0] f, input logic ok);
		@(posedge core_clk);
		{negReq, negSlot, negAsOwner, negExplicit, peerXcap} <= {1'b1, s, f};
		@(posedge core_clk);
		negReq <= 1'b0;
		@(negedge core_clk);
		chk({negDone, negOk}, {1'b1, ok});
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			sfTick <= 1'b1;
			@(posedge core_clk);
			sfTick <= 1'b0;
		end
	endtask
	task automatic sc_reset();
		repeat (10) @(posedge core_clk);
		chk({txDenyCode, annType}, {DC_OFF, RT_NONE});
		chk(availMap, 32'h0);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(availMap, 32'hFFFFFFFF);
	endtask
	task automatic sc_regs();
		apb(1'b0, ADDR_GUARD, 32'h0);
		chk(q, {16'h0, GUARD_RST});
		apb(1'b0, 8'h14, 32'h0);
		chk({e, q}, {1'b1, 32'h0});
		tx(mk(5'd1, 4'hA, 4'h5, 16'h0010), 1'b0, DC_OFF, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h3);
		repeat (2) @(negedge core_clk);
		chk(capExplicit, 1'b1);
	endtask
	task automatic sc_hard();
		wslot(5'd1, rec(RT_HARD, ROLE_OWNER, 1'b1, 1'b1, 4'h5));
		apb(1'b0, ADDR_SLOT, 32'h0);
		chk(q, {17'h0, rec(RT_HARD, ROLE_OWNER, 1'b1, 1'b1, 4'h5)});
		wslot(5'd2, rec(RT_HARD, ROLE_NBR, 1'b1, 1'b1, 4'h5));
		wslot(5'd3, rec(RT_HARD, ROLE_TARGET, 1'b1, 1'b1, 4'h5));
		wslot(5'd7, rec(RT_HARD, ROLE_OWNER, 1'b0, 1'b1, 4'h5));
		tx(mk(5'd1, 4'hA, 4'h5, 16'h0010), 1'b1, DC_OK, 1'b1);
		tx(mk(5'd1, 4'hA, 4'h6, 16'h0010), 1'b0, DC_STREAM, 1'b1);
		tx(mk(5'd1, 4'h2, 4'h0, 16'h00C0), 1'b1, DC_OK, 1'b1);
		tx(mk(5'd1, 4'h2, 4'h0, 16'h00C1), 1'b0, DC_TIME, 1'b1);
		@(posedge core_clk);
		blkUnused <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk(relSuggest, 1'b1);
		@(posedge core_clk);
		blkUnused <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk(relSuggest, 1'b0);
		tx(mk(5'd2, 4'h0, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		tx(mk(5'd3, 4'h2, 4'h0, 16'h0010), 1'b0, DC_ROLE, 1'b0);
		tx(mk(5'd3, 4'h0, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		tx(mk(5'd7, 4'hA, 4'h5, 16'h0010), 1'b0, DC_OK, 1'b0);
		ann(5'd1, 1'b1, RT_HARD);
		ann(5'd7, 1'b0, RT_HARD);
		chk(annSameGroup, 1'b1);
		ann(5'd3, 1'b1, RT_HARD);
		chk(annSameGroup, 1'b0);
	endtask
	task automatic sc_others();
		wslot(5'd8, rec(RT_PRIV, ROLE_NBR, 1'b1, 1'b1, 4'h0));
		wslot(5'd9, rec(RT_SOFT, ROLE_OWNER, 1'b1, 1'b1, 4'h2));
		wslot(5'd10, rec(RT_SOFT, ROLE_NBR, 1'b1, 1'b1, 4'h2));
		wslot(5'd11, rec(RT_SOFT, ROLE_NBR, 1'b1, 1'b0, 4'h2));
		tx(mk(5'd8, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		tx(mk(5'd9, 4'h2, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		chk(txNoBackoff, 1'b1);
		tx(mk(5'd9, 4'hA, 4'h3, 16'h0010), 1'b0, DC_OK, 1'b0);
		tx(mk(5'd10, 4'h2, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		tx(mk(5'd10, 4'h3, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		tx(mk(5'd11, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		tx(mk(5'd12, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
	endtask
	task automatic sc_alien_pca();
		nbr.ev(4'h4, 5'd4, '0);
		ann(5'd4, 1'b1, RT_ALIEN);
		tx(mk(5'd4, 4'h4, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		tx(mk(5'd4, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		// pca slot installed unconfirmed before any superframe tick, so the first confirm has no history
		wslot(5'd6, rec(RT_PCA, ROLE_OWNER, 1'b0, 1'b0, 4'h0));
		nbr.ev(4'h8, 5'd6, '0);
		ann(5'd6, 1'b0, RT_PCA);
		tick(1);
		nbr.ev(4'h8, 5'd6, '0);
		ann(5'd6, 1'b1, RT_PCA);
		tx(mk(5'd6, 4'h3, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		chk(txNoBackoff, 1'b0);
	endtask
	task automatic sc_neg();
		nbr.ev(4'h1, 5'd14, '{5'd14, RT_HARD, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0});
		nbr.ev(4'h1, 5'd15, '{5'd15, RT_HARD, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0});
		neg(5'd13, 3'b100, 1'b1);
		neg(5'd13, 3'b000, 1'b0);
		neg(5'd13, 3'b110, 1'b0);
		neg(5'd13, 3'b111, 1'b1);
		neg(5'd1, 3'b100, 1'b0);
		neg(5'd14, 3'b100, 1'b1);
		neg(5'd15, 3'b100, 1'b0);
	endtask
	task automatic sc_avail();
		nbr.ev(4'h2, 5'd20, '0);
		repeat (3) @(negedge core_clk);
		chk({availMap[20], availMap[1]}, 2'b00);
		tick(2);
		chk(availMap[20], 1'b0);
		tick(2);
		repeat (2) @(negedge core_clk);
		chk(availMap[20], 1'b1);
	endtask
	task automatic sc_release();
		@(posedge core_clk);
		{relRx, relSlot, relDur} <= {1'b1, 5'd2, 16'h0005};
		@(posedge core_clk);
		relRx <= 1'b0;
		tx(mk(5'd2, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
		repeat (10) @(posedge core_clk);
		tx(mk(5'd2, 4'h3, 4'h0, 16'h0010), 1'b1, DC_OK, 1'b0);
		@(posedge core_clk);
		blkEnd <= 1'b1;
		@(posedge core_clk);
		blkEnd <= 1'b0;
		tx(mk(5'd2, 4'h3, 4'h0, 16'h0010), 1'b0, DC_OK, 1'b0);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		sc_reset();
		sc_regs();
		sc_hard();
		sc_others();
		sc_alien_pca();
		sc_neg();
		sc_avail();
		sc_release();
		report_and_stop();
	end
	// watchdog, far beyond the expected run
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
